/* File: dma_address_ring_buffer.sv */
`timescale 1ns/1ps
// Contract
// RQ1 - Burst slave watches ready with read/write strobe for data timing.
// RQ2 - Burst cycle to non-burst memory falls back to two clocks.
// RQ3 - Sequence started on non-burst memory stays non-burst to its end.
// RQ4 - Channel 4 mode defaults to cascade; software keeps it so.
// RQ5 - Each channel holds 22 stop bits: one 6-bit, two 8-bit registers.
// RQ6 - Stop comparison enabled per channel by its control setting.
// RQ7 - Ring wraps: autoinit at count expiry reloads address from base.
// RQ8 - With stop enabled, last transfer is first stop match; then mask.
// RQ9 - Stop compares address bits 23 down to 2 only.
// RQ10 - Host rewrites stop pointer to last location it has read.
// RQ11 - Non-CPU masters leave one clock between register accesses.
// RQ12 - Programming uses 8-bit writes with channels masked.
// RQ13 - Low page byte, read/write, gives address bits 23:16.
// RQ14 - High page byte, read/write, gives address bits 31:24.
// RQ15 - Writing low page or current address clears high page.
// RQ16 - High page written last selects full 32-bit stepping.
// RQ17 - Compatibility mode: no carry into pages, high page zero.
// RQ18 - Writing any lower three address bytes selects compatibility.
// RQ19 - Reset and master clear return channels to compatibility mode.
// RQ20 - Software writes current address after a compatible page write.
// RQ21 - 16-bit current address, byte access, steps every transfer.
// RQ22 - Autoinit reloads address and pages only at count end or process end.
// RQ23 - Count decrements per transfer; wrap from zero raises terminal.
// RQ24 - A stop match sets the channel mask bit for software to see.
module dma_address_ring_buffer
(
  input wire logic clk,
  input wire logic rst,
  input wire dma_ring_pkg::io_req_t io_req,
  input wire dma_ring_pkg::xfer_req_t xfer_req,
  input wire logic master_clear,
  output logic [7:0] io_rdata_ff,
  output logic [31:0] xfer_addr_ff,
  output logic [1:0] cycle_bclks_ff,
  output logic terminal_count_ff,
  output logic [dma_ring_pkg::NUM_CH-1:0] chan_mask_ff
);
  import dma_ring_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Per-channel state
  // ----------------------------------------
  logic [15:0] cur_ff [NUM_CH];
  logic [7:0] lpg_ff [NUM_CH];
  logic [7:0] hpg_ff [NUM_CH];
  logic [15:0] base_cur_ff [NUM_CH];
  logic [7:0] base_lpg_ff [NUM_CH];
  logic [7:0] base_hpg_ff [NUM_CH];
  logic [23:0] cnt_ff [NUM_CH];
  logic [23:0] base_cnt_ff [NUM_CH];
  logic [21:0] stop_ff [NUM_CH];
  logic ext_ff [NUM_CH];
  chan_ctrl_t ctrl_ff [NUM_CH];

  logic [31:0] full_w [NUM_CH];
  logic [7:0] rd_w [NUM_CH];
  logic [NUM_CH-1:0] xfer_w;
  logic [NUM_CH-1:0] count_end_w;
  logic [NUM_CH-1:0] hit_w;
  logic [NUM_CH-1:0] nxt_mask;
  logic [1:0] bclks_w;

  wire [7:0] nxt_rdata = (io_req.idx == REG_MASK)
    ? {7'h00, chan_mask_ff[io_req.ch]} : rd_w[io_req.ch];

  // ----------------------------------------
  // Burst cycle length
  // ----------------------------------------
  // RQ1 is the slave's side: it paces data on ready and strobes
  dma_burst_ctl u_burst
  (
    .clk(clk),
    .rst(rst),
    .req(xfer_req),
    .cycle_bclks(bclks_w)
  );

  // ----------------------------------------
  // Channel address, count and stop logic
  // ----------------------------------------
  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    localparam logic [1:0] MODE_RST =
      (i == CASCADE_CH) ? MODE_CASCADE : MODE_DEMAND; // RQ4
    localparam chan_ctrl_t CTRL_RST = '{MODE_RST, 1'b0, 1'b0, 1'b0};

    wire wr_i = io_req.wr && (io_req.ch == 3'(i));
    wire [3:0] idx = io_req.idx;
    wire [7:0] d = io_req.data;
    wire compat_wr = wr_i && (idx == REG_ADDR_LO || idx == REG_ADDR_HI
      || idx == REG_LOW_PAGE);
    wire dec = ctrl_ff[i].decrement;
    wire [31:0] step32 = dec ? full_w[i] - 32'h1 : full_w[i] + 32'h1;
    wire [15:0] step16 = dec ? cur_ff[i] - 16'h1 : cur_ff[i] + 16'h1;
    wire reload = xfer_w[i] && ctrl_ff[i].autoinit
      && (count_end_w[i] || xfer_req.end_of_process); // RQ22
    wire mask_wr = wr_i && (idx == REG_MASK);
    // Mask stops stepping, so nothing goes past the stop match
    assign xfer_w[i] = xfer_req.ack && (xfer_req.ch == 3'(i))
      && !chan_mask_ff[i]; // RQ8
    assign full_w[i] = {hpg_ff[i], lpg_ff[i], cur_ff[i]}; // RQ13 RQ14
    assign count_end_w[i] = xfer_w[i] && (cnt_ff[i] == 24'h000000); // RQ23
    assign hit_w[i] = xfer_w[i] && ctrl_ff[i].stop_en // RQ6
      && (full_w[i][23:2] == stop_ff[i]); // RQ9
    // Set beats a clearing write in the same cycle
    assign nxt_mask[i] = hit_w[i] // RQ24
      || (count_end_w[i] && !ctrl_ff[i].autoinit)
      || (mask_wr ? d[0] : chan_mask_ff[i]);

    always_comb
    begin
      unique case (idx)
        REG_ADDR_LO: rd_w[i] = cur_ff[i][7:0];
        REG_ADDR_HI: rd_w[i] = cur_ff[i][15:8];
        REG_LOW_PAGE: rd_w[i] = lpg_ff[i];
        REG_HIGH_PAGE: rd_w[i] = hpg_ff[i];
        REG_CNT_LO: rd_w[i] = cnt_ff[i][7:0];
        REG_CNT_MID: rd_w[i] = cnt_ff[i][15:8];
        REG_CNT_HI: rd_w[i] = cnt_ff[i][23:16];
        REG_STOP_LO: rd_w[i] = {stop_ff[i][5:0], 2'h0};
        REG_STOP_MID: rd_w[i] = stop_ff[i][13:6];
        REG_STOP_HI: rd_w[i] = stop_ff[i][21:14];
        REG_CTRL: rd_w[i] = {3'h0, ctrl_ff[i]};
        default: rd_w[i] = 8'h00;
      endcase
    end

    always_ff @(posedge clk)
    begin
      if (rst || master_clear)
      begin
        ext_ff[i] <= 1'b0; // RQ19
        hpg_ff[i] <= HIGH_PAGE_RST;
        base_hpg_ff[i] <= HIGH_PAGE_RST;
        ctrl_ff[i] <= CTRL_RST;
      end
      else if (wr_i)
      begin
        if (compat_wr)
        begin
          ext_ff[i] <= 1'b0; // RQ18
          hpg_ff[i] <= HIGH_PAGE_RST; // RQ15
          base_hpg_ff[i] <= HIGH_PAGE_RST;
        end
        if (idx == REG_HIGH_PAGE)
        begin
          ext_ff[i] <= 1'b1; // RQ16
          hpg_ff[i] <= d; // RQ14
          base_hpg_ff[i] <= d;
        end
        if (idx == REG_CTRL)
          ctrl_ff[i] <= chan_ctrl_t'(d[4:0]); // RQ6
      end
      else if (reload)
        hpg_ff[i] <= base_hpg_ff[i]; // RQ22
      else if (xfer_w[i] && ext_ff[i])
        hpg_ff[i] <= step32[31:24]; // RQ16
    end

    always_ff @(posedge clk)
    begin
      if (rst)
      begin
        cur_ff[i] <= 16'h0000;
        lpg_ff[i] <= 8'h00;
        base_cur_ff[i] <= 16'h0000;
        base_lpg_ff[i] <= 8'h00;
        cnt_ff[i] <= 24'h000000;
        base_cnt_ff[i] <= 24'h000000;
        stop_ff[i] <= 22'h000000;
      end
      else if (wr_i)
      begin
        unique case (idx)
          REG_ADDR_LO:
          begin
            cur_ff[i][7:0] <= d; // RQ21
            base_cur_ff[i][7:0] <= d;
          end
          REG_ADDR_HI:
          begin
            cur_ff[i][15:8] <= d; // RQ21
            base_cur_ff[i][15:8] <= d;
          end
          REG_LOW_PAGE:
          begin
            lpg_ff[i] <= d; // RQ13
            base_lpg_ff[i] <= d;
          end
          // Older software never writes the top count byte
          REG_CNT_LO:
          begin
            cnt_ff[i] <= {8'h00, cnt_ff[i][15:8], d};
            base_cnt_ff[i] <= {8'h00, base_cnt_ff[i][15:8], d};
          end
          REG_CNT_MID:
          begin
            cnt_ff[i] <= {8'h00, d, cnt_ff[i][7:0]};
            base_cnt_ff[i] <= {8'h00, d, base_cnt_ff[i][7:0]};
          end
          REG_CNT_HI:
          begin
            cnt_ff[i][23:16] <= d;
            base_cnt_ff[i][23:16] <= d;
          end
          REG_STOP_LO: stop_ff[i][5:0] <= d[7:2]; // RQ5
          REG_STOP_MID: stop_ff[i][13:6] <= d; // RQ5
          REG_STOP_HI: stop_ff[i][21:14] <= d; // RQ5
          default:
          begin
          end
        endcase
      end
      else if (reload)
      begin
        cur_ff[i] <= base_cur_ff[i]; // RQ7
        lpg_ff[i] <= base_lpg_ff[i]; // RQ22
        cnt_ff[i] <= base_cnt_ff[i];
      end
      else if (xfer_w[i])
      begin
        cnt_ff[i] <= cnt_ff[i] - 24'h000001; // RQ23
        if (ext_ff[i])
        begin
          cur_ff[i] <= step32[15:0]; // RQ16
          lpg_ff[i] <= step32[23:16];
        end
        else
          cur_ff[i] <= step16; // RQ17
      end
    end

    // ----------------------------------------
    // Channel checks
    // ----------------------------------------
    chk_page_clear: assert property ( // RQ15
      compat_wr |=> hpg_ff[i] == HIGH_PAGE_RST && !ext_ff[i])
      else $error("address write did not clear high page");
    chk_ext_enter: assert property ( // RQ16
      wr_i && idx == REG_HIGH_PAGE && !master_clear
      |=> ext_ff[i] && hpg_ff[i] == $past(io_req.data))
      else $error("high page write did not enter extended mode");
    chk_compat_step: assert property ( // RQ17
      xfer_w[i] && !ext_ff[i] && !reload && !wr_i && !master_clear
      |=> hpg_ff[i] == $past(hpg_ff[i]) && lpg_ff[i] == $past(lpg_ff[i]))
      else $error("carry reached page in compatibility mode");
    chk_ext_step: assert property ( // RQ16
      xfer_w[i] && ext_ff[i] && !dec && !reload && !wr_i && !master_clear
      |=> full_w[i] == $past(full_w[i]) + 32'h1)
      else $error("extended address did not step by one");
    chk_count_wrap: assert property ( // RQ23
      xfer_w[i] && cnt_ff[i] == 24'h000000 && !ctrl_ff[i].autoinit
      && !wr_i |=> cnt_ff[i] == CNT_ALL_ONES && chan_mask_ff[i])
      else $error("count did not wrap to all ones");
    chk_autoinit_load: assert property ( // RQ22
      reload && !wr_i && !master_clear
      |=> cur_ff[i] == $past(base_cur_ff[i])
      && lpg_ff[i] == $past(base_lpg_ff[i])
      && hpg_ff[i] == $past(base_hpg_ff[i]))
      else $error("autoinitialize did not restore address");
    chk_stop_mask: assert property ( // RQ24
      hit_w[i] |=> chan_mask_ff[i] ##1 chan_mask_ff[i] || $past(mask_wr))
      else $error("stop match did not mask channel");
    chk_masked_idle: assert property ( // RQ8
      chan_mask_ff[i] && !wr_i && !master_clear
      |=> full_w[i] == $past(full_w[i]))
      else $error("masked channel moved its address");
    chk_reset_mode: assert property ( // RQ19
      $past(rst) |-> !ext_ff[i] && ctrl_ff[i].mode == MODE_RST)
      else $error("reset left channel out of default mode");
  end

  // ----------------------------------------
  // Output and mask registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst || master_clear)
      chan_mask_ff <= {NUM_CH{1'b1}};
    else
      chan_mask_ff <= nxt_mask;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      io_rdata_ff <= 8'h00;
      xfer_addr_ff <= 32'h00000000;
      cycle_bclks_ff <= NONBURST_BCLKS;
      terminal_count_ff <= 1'b0;
    end
    else
    begin
      if (io_req.rd)
        io_rdata_ff <= nxt_rdata;
      if (xfer_req.ack)
      begin
        xfer_addr_ff <= full_w[xfer_req.ch];
        cycle_bclks_ff <= bclks_w; // RQ2
      end
      terminal_count_ff <= |count_end_w; // RQ23
    end
  end

  chk_addr_present: assert property ( // RQ21
    xfer_req.ack ##1 1'b1 |-> xfer_addr_ff == $past(full_w[xfer_req.ch]))
    else $error("presented address is not the channel address");

  cov_stop_hit: cover property (|hit_w ##1 |chan_mask_ff);
  cov_autoinit: cover property (
    |(count_end_w & ~nxt_mask) && |count_end_w);
  cov_ext_run: cover property (xfer_req.ack && ext_ff[xfer_req.ch]);
  cov_two_clk: cover property (xfer_req.ack && bclks_w == NONBURST_BCLKS);

endmodule // dma_address_ring_buffer

/* File: dma_address_ring_buffer_test.sv */
`timescale 1ns/1ps
module dma_address_ring_buffer_test;
  import dma_ring_pkg::*;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic master_clear = 1'b0;
  io_req_t io_req = '0;
  xfer_req_t xfer_req;
  logic [7:0] io_rdata_ff;
  logic [31:0] xfer_addr_ff;
  logic [1:0] cycle_bclks_ff;
  logic terminal_count_ff;
  logic [NUM_CH-1:0] chan_mask_ff;
  int miscompares = 0;
  int n_checks = 0;
  logic [7:0] ai [5] = '{8'h40, 8'h41, 8'h42, 8'h40, 8'h40};

  always #25 clk = ~clk;

  dma_address_ring_buffer i_dut (.clk(clk), .rst(rst), .io_req(io_req),
    .xfer_req(xfer_req), .master_clear(master_clear),
    .io_rdata_ff(io_rdata_ff), .xfer_addr_ff(xfer_addr_ff),
    .cycle_bclks_ff(cycle_bclks_ff),
    .terminal_count_ff(terminal_count_ff), .chan_mask_ff(chan_mask_ff));

  xfer_engine_model i_mem (.clk(clk), .req(xfer_req));

  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp,
                          input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_addr(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------
  // Register access and transfers
  // ----------------------------------------
  // Callers keep the channel masked while programming it
  task automatic wr(input logic [2:0] ch, input logic [3:0] idx,
                    input logic [7:0] d);
    @(posedge clk);
    io_req <= '{wr: 1'b1, rd: 1'b0, ch: ch, idx: idx, data: d};
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b0, ch: ~ch, idx: ~idx, data: ~d};
  endtask

  task automatic rc(input logic [2:0] ch, input logic [3:0] idx,
                    input logic [7:0] exp, input string what);
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b1, ch: ch, idx: idx, data: 8'h00};
    @(posedge clk);
    io_req <= '{wr: 1'b0, rd: 1'b0, ch: ~ch, idx: ~idx, data: 8'hFF};
    #1 chk_byte(what, exp, io_rdata_ff);
  endtask

  // High page written last only when ext is set
  task automatic prog(input logic [2:0] ch, input logic [15:0] a,
                      input logic [7:0] lp, input logic [7:0] hp,
                      input logic ext, input logic [7:0] cnt,
                      input logic [7:0] ctrl);
    wr(ch, REG_ADDR_LO, a[7:0]);
    wr(ch, REG_ADDR_HI, a[15:8]);
    wr(ch, REG_LOW_PAGE, lp);
    if (ext)
      wr(ch, REG_HIGH_PAGE, hp);
    wr(ch, REG_CNT_LO, cnt);
    wr(ch, REG_CTRL, ctrl);
  endtask

  task automatic xa(input logic [2:0] ch, input logic last,
                    input logic [31:0] exp);
    i_mem.xfer(ch, 1'b0, 1'b0, 1'b0, last);
    #1 chk_addr("transfer address", exp, xfer_addr_ff);
  endtask

  task automatic xb(input logic ok, input logic seq, input logic [1:0] exp);
    i_mem.xfer(3'd5, 1'b1, ok, seq, 1'b0);
    #1 chk_byte("cycle clocks", {6'h00, exp}, {6'h00, cycle_bclks_ff});
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk_byte("mask after reset", 8'hFF, chan_mask_ff);
    rc(3'd2, REG_HIGH_PAGE, 8'h00, "high page reset");
    rc(3'd4, REG_CTRL, 8'h18, "cascade mode");
    wr(3'd2, 4'hC, 8'h5A);
    rc(3'd2, 4'hC, 8'h00, "reserved byte");
    wr(3'd2, REG_LOW_PAGE, 8'h12);
    wr(3'd2, REG_HIGH_PAGE, 8'h34);
    rc(3'd2, REG_LOW_PAGE, 8'h12, "low page");
    rc(3'd2, REG_HIGH_PAGE, 8'h34, "high page");
    wr(3'd2, REG_LOW_PAGE, 8'h56);
    rc(3'd2, REG_HIGH_PAGE, 8'h00, "high page after page");
    wr(3'd2, REG_HIGH_PAGE, 8'h34);
    wr(3'd2, REG_ADDR_LO, 8'h00);
    rc(3'd2, REG_HIGH_PAGE, 8'h00, "high page after addr");
    wr(3'd2, REG_STOP_MID, 8'hA5);
    rc(3'd2, REG_STOP_MID, 8'hA5, "stop middle byte");
    prog(3'd1, 16'hFFFF, 8'h12, 8'h34, 1'b1, 8'h01, 8'h00);
    wr(3'd1, REG_MASK, 8'h00);
    xa(3'd1, 1'b0, 32'h3412FFFF);
    xa(3'd1, 1'b0, 32'h34130000);
    chk_byte("terminal count", 8'h01, {7'h00, terminal_count_ff});
    @(posedge clk);
    #1 chk_byte("mask after count", 8'h01, {7'h00, chan_mask_ff[1]});
    rc(3'd1, REG_LOW_PAGE, 8'h13, "carried low page");
    rc(3'd1, REG_ADDR_LO, 8'h01, "address low byte");
    rc(3'd1, REG_CNT_HI, 8'hFF, "wrapped count");
    prog(3'd3, 16'hFFFF, 8'h05, 8'h07, 1'b1, 8'h05, 8'h00);
    @(posedge clk);
    master_clear <= 1'b1;
    @(posedge clk);
    master_clear <= 1'b0;
    #1 chk_byte("mask after clear", 8'hFF, chan_mask_ff);
    rc(3'd3, REG_HIGH_PAGE, 8'h00, "high page after clear");
    wr(3'd3, REG_MASK, 8'h00);
    xa(3'd3, 1'b0, 32'h0005FFFF);
    xa(3'd3, 1'b0, 32'h00050000);
    prog(3'd0, 16'h0100, 8'h00, 8'h00, 1'b0, 8'h05, 8'h02);
    wr(3'd0, REG_MASK, 8'h00);
    xa(3'd0, 1'b0, 32'h00000100);
    xa(3'd0, 1'b0, 32'h000000FF);
    // Count of two: the third ack reloads, the fourth carries end_of_process
    prog(3'd5, 16'h0040, 8'h02, 8'h00, 1'b0, 8'h02, 8'h01);
    wr(3'd5, REG_MASK, 8'h00);
    for (int i = 0; i < 5; i++)
      xa(3'd5, i == 3, {24'h000200, ai[i]});
    chk_byte("autoinit mask", 8'h00, {7'h00, chan_mask_ff[5]});
    xb(1'b1, 1'b1, BURST_BCLKS);
    xb(1'b0, 1'b1, NONBURST_BCLKS);
    xb(1'b1, 1'b0, NONBURST_BCLKS);
    i_mem.xfer_pair(3'd5, 1'b0, 1'b1);
    #1 chk_byte("paired clocks", 8'h02, {6'h00, cycle_bclks_ff});
    xb(1'b1, 1'b1, BURST_BCLKS);
    prog(3'd6, 16'h0018, 8'h00, 8'h99, 1'b1, 8'h10, 8'h04);
    wr(3'd6, REG_STOP_LO, 8'h1F);
    rc(3'd6, REG_STOP_LO, 8'h1C, "stop low byte");
    wr(3'd6, REG_MASK, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      xa(3'd6, 1'b0, 32'h99000018 + i);
      @(posedge clk);
      #1 chk_byte("stop mask", {7'h00, i == 4},
                  {7'h00, chan_mask_ff[6]});
    end
    repeat (2) xa(3'd6, 1'b0, 32'h9900001D);
    wr(3'd6, REG_STOP_LO, 8'h2C);
    wr(3'd6, REG_MASK, 8'h00);
    xa(3'd6, 1'b0, 32'h9900001D);
    prog(3'd7, 16'h001C, 8'h00, 8'h00, 1'b0, 8'h05, 8'h00);
    wr(3'd7, REG_STOP_LO, 8'h1C);
    wr(3'd7, REG_MASK, 8'h00);
    xa(3'd7, 1'b0, 32'h0000001C);
    @(posedge clk);
    #1 chk_byte("stop off mask", 8'h00, {7'h00, chan_mask_ff[7]});
    stop_test();
  end

  // Whole sequence needs well under a third of this span
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule // dma_address_ring_buffer_test

/* File: dma_burst_ctl.sv */
`timescale 1ns/1ps
module dma_burst_ctl
(
  input wire logic clk,
  input wire logic rst,
  input wire dma_ring_pkg::xfer_req_t req,
  output logic [1:0] cycle_bclks
);
  import dma_ring_pkg::*;

  logic first_ff;
  logic lock_ff;
  wire first_w = req.seq_start | first_ff;
  wire lock_set_w = req.ack & first_w & req.burst & ~req.mem_burst_ok;
  wire nxt_first = req.ack ? 1'b0 : first_w;
  wire nxt_lock = lock_set_w ? 1'b1 : (req.seq_start ? 1'b0 : lock_ff);
  // Locked sequence stays slow even on burst-capable pages
  wire nonburst_w = ~req.mem_burst_ok | (lock_ff & ~req.seq_start); // RQ3

  assign cycle_bclks = nonburst_w ? NONBURST_BCLKS : BURST_BCLKS; // RQ2

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      first_ff <= 1'b0;
      lock_ff <= 1'b0;
    end
    else
    begin
      first_ff <= nxt_first;
      lock_ff <= nxt_lock;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_nonburst_len: assert property ( // RQ2
    req.ack && req.burst && !req.mem_burst_ok
    |-> cycle_bclks == NONBURST_BCLKS)
    else $error("non-burst memory not given two clocks");
  chk_lock_hold: assert property ( // RQ3
    (req.ack && first_w && req.burst && !req.mem_burst_ok)
    ##1 (req.ack && !req.seq_start)
    |-> cycle_bclks == NONBURST_BCLKS)
    else $error("burst resumed inside locked sequence");
  cov_lock: cover property (lock_set_w ##1 req.ack && req.mem_burst_ok);

endmodule // dma_burst_ctl

/* File: dma_ring_pkg.sv */
package dma_ring_pkg;

  // ----------------------------------------
  // Channel layout
  // ----------------------------------------
  localparam int NUM_CH = 8;
  localparam int CASCADE_CH = 4;

  // ----------------------------------------
  // Byte register index, one per 8-bit access
  // ----------------------------------------
  localparam logic [3:0] REG_ADDR_LO = 4'h0;
  localparam logic [3:0] REG_ADDR_HI = 4'h1;
  localparam logic [3:0] REG_LOW_PAGE = 4'h2;
  localparam logic [3:0] REG_HIGH_PAGE = 4'h3;
  localparam logic [3:0] REG_CNT_LO = 4'h4;
  localparam logic [3:0] REG_CNT_MID = 4'h5;
  localparam logic [3:0] REG_CNT_HI = 4'h6;
  localparam logic [3:0] REG_STOP_LO = 4'h7;
  localparam logic [3:0] REG_STOP_MID = 4'h8;
  localparam logic [3:0] REG_STOP_HI = 4'h9;
  localparam logic [3:0] REG_CTRL = 4'hA;
  localparam logic [3:0] REG_MASK = 4'hB;

  // ----------------------------------------
  // Modes, reset values, timing
  // ----------------------------------------
  localparam logic [1:0] MODE_DEMAND = 2'h0;
  localparam logic [1:0] MODE_CASCADE = 2'h3;
  localparam logic [7:0] HIGH_PAGE_RST = 8'h00;
  localparam logic [23:0] CNT_ALL_ONES = 24'hFFFFFF;
  localparam logic [1:0] NONBURST_BCLKS = 2'h2;
  localparam logic [1:0] BURST_BCLKS = 2'h1;

  // Control byte bits [4:0]
  typedef struct packed {
    logic [1:0] mode;
    logic stop_en;
    logic decrement;
    logic autoinit;
  } chan_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] ch;
    logic [3:0] idx;
    logic [7:0] data;
  } io_req_t;

  typedef struct packed {
    logic ack;
    logic [2:0] ch;
    logic end_of_process;
    logic burst;
    logic mem_burst_ok;
    logic seq_start;
  } xfer_req_t;

endpackage

/* File: xfer_engine_model.sv */
`timescale 1ns/1ps
module xfer_engine_model
(
  input wire logic clk,
  output dma_ring_pkg::xfer_req_t req
);
  import dma_ring_pkg::*;

  // ----------------------------------------
  // Cycle engine and memory side
  // ----------------------------------------
  initial req = '0;

  // Slave paces data by ready and strobe; one ack per finished transfer
  task automatic xfer(input logic [2:0] ch, input logic burst,
                      input logic mem_ok, input logic seq,
                      input logic last);
    @(posedge clk);
    req <= '{ack: 1'b1, ch: ch, end_of_process: last, burst: burst,
             mem_burst_ok: mem_ok, seq_start: seq};
    @(posedge clk);
    // Released qualifiers show the inverse, except seq_start, which drops to zero
    req <= '{ack: 1'b0, ch: ~ch, end_of_process: ~last, burst: ~burst,
             mem_burst_ok: ~mem_ok, seq_start: 1'b0};
  endtask

  // Two acks on consecutive edges, as inside a running burst
  task automatic xfer_pair(input logic [2:0] ch, input logic mem_ok1,
                           input logic mem_ok2);
    @(posedge clk);
    req <= '{ack: 1'b1, ch: ch, end_of_process: 1'b0, burst: 1'b1,
             mem_burst_ok: mem_ok1, seq_start: 1'b1};
    @(posedge clk);
    req <= '{ack: 1'b1, ch: ch, end_of_process: 1'b0, burst: 1'b1,
             mem_burst_ok: mem_ok2, seq_start: 1'b0};
    @(posedge clk);
    req <= '{ack: 1'b0, ch: ~ch, end_of_process: 1'b1, burst: 1'b0,
             mem_burst_ok: ~mem_ok2, seq_start: 1'b0};
  endtask
endmodule // xfer_engine_model
